// File: design/scb_params.svh
// constants of the sdram command and burst controller
`ifndef SCB_PARAMS_SVH
`define SCB_PARAMS_SVH
// ****************************************
// register word indices
// ****************************************
`define SCB_REG_CMD 4'h0
`define SCB_REG_STATUS 4'h1
`define SCB_REG_CFG 4'h2
`define SCB_REG_BUF 4'h8
// ****************************************
// field positions
// ****************************************
`define SCB_CMD_OP_LSB 0
`define SCB_CMD_BANK_LSB 4
`define SCB_CMD_ADDR_LSB 8
`define SCB_ST_PEND_BIT 0
`define SCB_ST_BUSY_BIT 1
`define SCB_ST_ERR_BIT 2
`define SCB_ST_OPEN_LSB 4
`define SCB_ST_RDIDX_LSB 8
`define SCB_CFG_LEN_LSB 0
`define SCB_CFG_ILV_BIT 3
`define SCB_CFG_CL_LSB 4
`define SCB_ADDR_ALL_BIT 10
// ****************************************
// reset values and codes
// ****************************************
`define SCB_CFG_RESET 8'h23
`define SCB_LEN_FULL 3'h7
// ****************************************
// timing, link cycle is two clock periods
// ****************************************
`define SCB_CLK_NS 100
`define SCB_SDR_NS (2 * `SCB_CLK_NS)
`define SCB_TRSC_NS 400
`define SCB_TRCD_NS 400
`define SCB_TRC_NS 1200
`define SCB_TRRD_NS 400
`define SCB_TRASMAX_NS 100000
`define SCB_RSC_CYC ((`SCB_TRSC_NS + `SCB_SDR_NS - 1) / `SCB_SDR_NS)
`define SCB_RCD_CYC ((`SCB_TRCD_NS + `SCB_SDR_NS - 1) / `SCB_SDR_NS)
`define SCB_RC_CYC ((`SCB_TRC_NS + `SCB_SDR_NS - 1) / `SCB_SDR_NS)
`define SCB_RRD_CYC ((`SCB_TRRD_NS + `SCB_SDR_NS - 1) / `SCB_SDR_NS)
`define SCB_RASMAX_CYC (`SCB_TRASMAX_NS / `SCB_SDR_NS)
`define SCB_MASK_CYC 2
`endif

// File: design/scb_pkg.sv
// types of the sdram command and burst controller
package scb_pkg;
    typedef enum logic [2:0] {
        SCB_OP_NOP = 3'h0, SCB_OP_MRS = 3'h1, SCB_OP_ACT = 3'h2, SCB_OP_PRE = 3'h3,
        SCB_OP_RD = 3'h4, SCB_OP_WR = 3'h5, SCB_OP_BST = 3'h6
    } scb_op_t;
    typedef enum logic [1:0] {
        SCB_ST_IDLE = 2'b00,
        SCB_ST_MASK = 2'b01
    } scb_state_t;
    typedef struct packed {
        scb_op_t op;
        logic [1:0] bank;
        logic [12:0] addr;
    } scb_cmd_t;
    typedef struct packed {
        logic cke;
        logic csN;
        logic rasN;
        logic casN;
        logic weN;
        logic [1:0] bank;
        logic [12:0] addr;
        logic [1:0] dqm;
    } scb_pins_t;
endpackage : scb_pkg

// File: design/scb_sdram_ctrl.sv
// sdram command and burst controller with avalon register port
`timescale 1ns/1ps
`include "scb_params.svh"
module scb_sdram_ctrl
    import scb_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int AGE_W = 10
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [3:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    output logic sdramClk,
    output scb_pins_t sdramPins,
    output logic [DATA_W-1:0] dqOut,
    output logic dqOe,
    input wire logic [DATA_W-1:0] dqIn
);
    // ****************************************
    // helpers
    // ****************************************
    // burst length in words, zero for full page
    function automatic logic [3:0] lenOf(input logic [2:0] code);
        case (code)
            3'h0: lenOf = 4'h1;
            3'h1: lenOf = 4'h2;
            3'h2: lenOf = 4'h4;
            3'h3: lenOf = 4'h8;
            default: lenOf = 4'h0;
        endcase
    endfunction : lenOf

    // saturating age step
    function automatic logic [AGE_W-1:0] ageInc(input logic [AGE_W-1:0] a);
        ageInc = (&a) ? a : a + 1'b1;
    endfunction : ageInc

    // ras, cas, we levels for an operation
    function automatic logic [2:0] strobes(input scb_op_t op);
        case (op)
            SCB_OP_MRS: strobes = 3'b000;
            SCB_OP_ACT: strobes = 3'b011;
            SCB_OP_PRE: strobes = 3'b010;
            SCB_OP_RD: strobes = 3'b101;
            SCB_OP_WR: strobes = 3'b100;
            SCB_OP_BST: strobes = 3'b110;
            default: strobes = 3'b111;
        endcase
    endfunction : strobes

    // ****************************************
    // storage
    // ****************************************
    logic waitReq_q;
    logic [31:0] readData_q;
    scb_cmd_t pend_q;
    logic pendValid_q;
    logic err_q;
    logic [7:0] cfg_q;
    logic [DATA_W-1:0] wbuf_q [8];
    logic [DATA_W-1:0] rbuf_q [8];
    logic [2:0] rdIdx_q;
    logic sdramClk_q;
    scb_pins_t pins_q;
    logic [DATA_W-1:0] dqOut_q;
    logic dqOe_q;
    logic [DATA_W-1:0] dqSync1_q;
    logic [DATA_W-1:0] dqSync2_q;
    logic [3:0] open_q;
    logic [AGE_W-1:0] bankAge_q [4];
    logic [AGE_W-1:0] rrdAge_q;
    logic [AGE_W-1:0] rscAge_q;
    logic ckeReady_q;
    scb_state_t state_q;
    logic maskCnt_q;
    logic maskDone_q;
    logic [3:0] rdLeft_q;
    logic rdFull_q;
    logic [3:0] wrLeft_q;
    logic wrFull_q;
    logic [2:0] wrIdx_q;
    logic [7:0] pipe_q;
    logic [7:0] pipeFirst_q;

    // ****************************************
    // register port decode
    // ****************************************
    wire busReq = (avsRead | avsWrite) & waitReq_q;
    wire isCmd = avsAddress == `SCB_REG_CMD;
    wire isBuf = avsAddress[3] == `SCB_REG_BUF >> 3;
    wire reqOk = busReq & ~(avsWrite & isCmd & pendValid_q);
    wire cmdLoad = reqOk & avsWrite & isCmd;
    wire errClr = reqOk & avsWrite & (avsAddress == `SCB_REG_STATUS) & avsWriteData[`SCB_ST_ERR_BIT];
    wire cfgLoad = reqOk & avsWrite & (avsAddress == `SCB_REG_CFG);
    wire bufLoad = reqOk & avsWrite & isBuf;
    wire [2:0] lenCode = cfg_q[`SCB_CFG_LEN_LSB +: 3];
    wire [1:0] casLat = cfg_q[`SCB_CFG_CL_LSB +: 2];
    wire isFull = lenCode == `SCB_LEN_FULL;
    wire [3:0] burstLen = lenOf(lenCode);
    wire burstBusy = (rdLeft_q != 4'h0) | rdFull_q | (wrLeft_q != 4'h0) | wrFull_q;
    logic [31:0] statusWord;
    logic [31:0] rdMux;

    // status and readback words
    always_comb begin
        statusWord = 32'h0;
        statusWord[`SCB_ST_PEND_BIT] = pendValid_q;
        statusWord[`SCB_ST_BUSY_BIT] = burstBusy | (state_q != SCB_ST_IDLE);
        statusWord[`SCB_ST_ERR_BIT] = err_q;
        statusWord[`SCB_ST_OPEN_LSB +: 4] = open_q;
        statusWord[`SCB_ST_RDIDX_LSB +: 3] = rdIdx_q;
        rdMux = 32'h0;
        if (isBuf) begin
            rdMux = 32'(rbuf_q[avsAddress[2:0]]);
        end else if (isCmd) begin
            rdMux = {11'h0, pend_q.addr, 2'h0, pend_q.bank, 1'b0, pend_q.op}; // same layout as written
        end else if (avsAddress == `SCB_REG_STATUS) begin
            rdMux = statusWord;
        end else if (avsAddress == `SCB_REG_CFG) begin
            rdMux = 32'(cfg_q);
        end
    end

    // ****************************************
    // link timing and command choice
    // ****************************************
    wire tick = sdramClk_q; // pins change as the link clock falls
    wire [1:0] pb = pend_q.bank;
    wire allowAny = rscAge_q >= AGE_W'(`SCB_RSC_CYC);
    wire mrsOk = (open_q == 4'h0) & ckeReady_q & ~burstBusy;
    wire actOk = ~open_q[pb] & (bankAge_q[pb] >= AGE_W'(`SCB_RC_CYC))
        & (rrdAge_q >= AGE_W'(`SCB_RRD_CYC));
    wire rwOk = open_q[pb] & (bankAge_q[pb] >= AGE_W'(`SCB_RCD_CYC));
    wire bstOk = isFull;
    wire legal = (pend_q.op == SCB_OP_MRS) ? mrsOk :
        (pend_q.op == SCB_OP_ACT) ? actOk :
        (pend_q.op == SCB_OP_RD || pend_q.op == SCB_OP_WR) ? rwOk :
        (pend_q.op == SCB_OP_BST) ? bstOk : 1'b1;
    wire [3:0] overAge;
    genvar g;
    for (g = 0; g < 4; g++) begin : gAge
        assign overAge[g] = open_q[g] & (bankAge_q[g] >= AGE_W'(`SCB_RASMAX_CYC - 1));
    end
    wire forceHit = tick & (state_q == SCB_ST_IDLE) & (|overAge);
    wire [1:0] forceBank = overAge[0] ? 2'd0 : overAge[1] ? 2'd1 : overAge[2] ? 2'd2 : 2'd3;
    wire considered = tick & pendValid_q & allowAny & ~forceHit & (state_q == SCB_ST_IDLE);
    wire readInFlight = (rdLeft_q != 4'h0) | rdFull_q | (|pipe_q);
    wire needMask = (pend_q.op == SCB_OP_WR) & readInFlight & ~maskDone_q;
    wire enterMask = considered & legal & needMask;
    wire take = considered & legal & ~needMask;
    wire drop = considered & ~legal;
    wire takeRd = take & (pend_q.op == SCB_OP_RD);
    wire takeWr = take & (pend_q.op == SCB_OP_WR);
    wire takeBst = take & (pend_q.op == SCB_OP_BST);
    wire takeAct = take & (pend_q.op == SCB_OP_ACT);
    wire takePre = take & (pend_q.op == SCB_OP_PRE);
    wire preAll = pend_q.addr[`SCB_ADDR_ALL_BIT];
    wire rdStep = tick & ~takeRd & ((rdLeft_q != 4'h0) | rdFull_q) & ~enterMask;
    wire wrStep = tick & ~takeWr & ~takeRd & ~takeBst & ((wrLeft_q != 4'h0) | wrFull_q);
    wire capture = tick & pipe_q[casLat];
    wire [2:0] strb = strobes(take ? pend_q.op : SCB_OP_NOP);

    // ****************************************
    // register port
    // ****************************************
    // one wait cycle, then the answer; a command write waits longer while a command is pending
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            waitReq_q <= 1'b1;
            readData_q <= 32'h0;
        end else begin
            waitReq_q <= ~reqOk;
            if (reqOk) begin
                readData_q <= rdMux;
            end
        end
    end

    // pending command, config, error flag (set beats clear)
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pend_q <= '0;
            pendValid_q <= 1'b0;
            cfg_q <= `SCB_CFG_RESET;
            err_q <= 1'b0;
        end else begin
            if (cmdLoad) begin
                pend_q.op <= scb_op_t'(avsWriteData[`SCB_CMD_OP_LSB +: 3]);
                pend_q.bank <= avsWriteData[`SCB_CMD_BANK_LSB +: 2];
                pend_q.addr <= avsWriteData[`SCB_CMD_ADDR_LSB +: 13];
            end
            pendValid_q <= cmdLoad | (pendValid_q & ~take & ~drop);
            if (cfgLoad) begin
                cfg_q <= avsWriteData[7:0];
            end
            err_q <= drop | (err_q & ~errClr);
        end
    end

    // data words, indexed storage
    always_ff @(posedge clock) begin
        if (bufLoad) begin
            wbuf_q[avsAddress[2:0]] <= avsWriteData[DATA_W-1:0];
        end
        if (capture) begin
            rbuf_q[pipeFirst_q[casLat] ? 3'd0 : rdIdx_q] <= dqSync2_q;
        end
    end

    // ****************************************
    // link pins
    // ****************************************
    // link clock divider and input synchroniser
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sdramClk_q <= 1'b0;
            dqSync1_q <= '0;
            dqSync2_q <= '0;
        end else begin
            sdramClk_q <= ~sdramClk_q;
            dqSync1_q <= dqIn;
            dqSync2_q <= dqSync1_q;
        end
    end

    // command pins, driven once per link cycle
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pins_q <= '{cke: 1'b0, csN: 1'b1, rasN: 1'b1, casN: 1'b1, weN: 1'b1,
                bank: 2'h0, addr: 13'h0, dqm: 2'b11};
        end else if (tick) begin
            pins_q.cke <= 1'b1;
            pins_q.csN <= 1'b0;
            {pins_q.rasN, pins_q.casN, pins_q.weN} <= forceHit ? 3'b010 : strb;
            pins_q.bank <= forceHit ? forceBank : pend_q.bank;
            pins_q.addr <= forceHit ? 13'h0 : pend_q.addr;
            pins_q.dqm <= {2{state_q == SCB_ST_MASK || enterMask}};
        end
    end

    // write data, first word with the command
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            dqOut_q <= '0;
            dqOe_q <= 1'b0;
            wrIdx_q <= 3'h0;
            wrLeft_q <= 4'h0;
            wrFull_q <= 1'b0;
        end else if (tick) begin
            if (takeWr) begin
                dqOut_q <= wbuf_q[0];
                dqOe_q <= 1'b1;
                wrIdx_q <= 3'h1;
                wrLeft_q <= isFull ? 4'h0 : burstLen - 4'h1;
                wrFull_q <= isFull;
            end else if (wrStep) begin
                dqOut_q <= wbuf_q[wrIdx_q];
                dqOe_q <= 1'b1;
                wrIdx_q <= wrIdx_q + 3'h1;
                wrLeft_q <= wrFull_q ? 4'h0 : wrLeft_q - 4'h1;
            end else begin
                dqOe_q <= 1'b0;
                wrLeft_q <= 4'h0;
                wrFull_q <= 1'b0;
            end
        end
    end

    // read bookkeeping and capture pipe
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdLeft_q <= 4'h0;
            rdFull_q <= 1'b0;
            pipe_q <= 8'h00;
            pipeFirst_q <= 8'h00;
            rdIdx_q <= 3'h0;
        end else if (tick) begin
            pipe_q <= takeWr ? 8'h00 : {pipe_q[6:0], takeRd | rdStep};
            pipeFirst_q <= {pipeFirst_q[6:0], takeRd};
            if (takeRd) begin
                rdLeft_q <= isFull ? 4'h0 : burstLen - 4'h1;
                rdFull_q <= isFull;
            end else if (takeBst | takeWr | enterMask) begin
                rdLeft_q <= 4'h0;
                rdFull_q <= 1'b0;
            end else if (rdStep && !rdFull_q) begin
                rdLeft_q <= rdLeft_q - 4'h1;
            end
            if (capture) begin
                rdIdx_q <= pipeFirst_q[casLat] ? 3'h1 : rdIdx_q + 3'h1;
            end
        end
    end

    // ****************************************
    // bank timers and mask sequence
    // ****************************************
    // ages count link cycles since each activate, and since the last mode set
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            open_q <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                bankAge_q[i] <= '1;
            end
            rrdAge_q <= '1;
            rscAge_q <= '1;
            ckeReady_q <= 1'b0;
        end else if (tick) begin
            ckeReady_q <= pins_q.cke;
            for (int i = 0; i < 4; i++) begin
                bankAge_q[i] <= (takeAct && pb == i[1:0]) ? '0 : ageInc(bankAge_q[i]);
                if (takeAct && pb == i[1:0]) begin
                    open_q[i] <= 1'b1;
                end else if ((takePre && (preAll || pb == i[1:0])) || (forceHit && forceBank == i[1:0])) begin
                    open_q[i] <= 1'b0;
                end
            end
            rrdAge_q <= takeAct ? '0 : ageInc(rrdAge_q);
            rscAge_q <= (take && pend_q.op == SCB_OP_MRS) ? '0 : ageInc(rscAge_q);
        end
    end

    // three masked link cycles ahead of a write that cuts a read
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q <= SCB_ST_IDLE;
            maskCnt_q <= 1'b0;
            maskDone_q <= 1'b0;
        end else if (tick) begin
            case (state_q)
                SCB_ST_IDLE: begin
                    if (enterMask) begin
                        state_q <= SCB_ST_MASK;
                        maskCnt_q <= 1'b0;
                    end
                    if (take) begin
                        maskDone_q <= 1'b0;
                    end
                end
                SCB_ST_MASK: begin
                    maskCnt_q <= 1'b1;
                    if (maskCnt_q) begin
                        state_q <= SCB_ST_IDLE;
                        maskDone_q <= 1'b1;
                    end
                end
                default: state_q <= SCB_ST_IDLE;
            endcase
        end
    end

    // outputs straight from flops
    assign avsWaitRequest = waitReq_q;
    assign avsReadData = readData_q;
    assign sdramClk = sdramClk_q;
    assign sdramPins = pins_q;
    assign dqOut = dqOut_q;
    assign dqOe = dqOe_q;
endmodule : scb_sdram_ctrl

// File: verification/scb_sdram_ctrl_assertions.sv
// concurrent checks on the sdram controller ports
`timescale 1ns/1ps
`include "scb_params.svh"
module scb_sdram_ctrl_assertions
    import scb_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic avsRead,
    input wire logic avsWaitRequest,
    input wire logic sdramClk,
    input wire scb_pins_t sdramPins,
    input wire logic dqOe
);
    localparam int RSC = 2 * `SCB_RSC_CYC - 1;
    localparam int RCD = 2 * `SCB_RCD_CYC - 1;
    localparam int RC = 2 * `SCB_RC_CYC - 1;
    localparam int RRD = 2 * `SCB_RRD_CYC - 1;
    localparam int RAS = 2 * `SCB_RASMAX_CYC;
    // ****************************************
    // link command decode, one sample per link cycle
    // ****************************************
    wire lk = !sdramClk && !sdramPins.csN;
    wire [2:0] sb = {sdramPins.rasN, sdramPins.casN, sdramPins.weN};
    wire [1:0] bk = sdramPins.bank;
    wire isMrs = lk && sb == 3'h0;
    wire isAct = lk && sb == 3'h3;
    wire isPre = lk && sb == 3'h2;
    wire isRd = lk && sb == 3'h5;
    wire isWr = lk && sb == 3'h4;
    wire isBst = lk && sb == 3'h6;
    logic [15:0] age_q [4];
    logic [15:0] mrsAge_q, actAge_q;
    logic [3:0] open_q;
    logic [2:0] len_q;
    wire [3:0] over = {age_q[3] > RAS, age_q[2] > RAS, age_q[1] > RAS, age_q[0] > RAS};
    function automatic logic [15:0] inc(input logic [15:0] v, input logic clr);
        return clr ? 16'h0 : v + 16'(v != 16'hFFFF);
    endfunction : inc
    // clock ages since mode set and activates, saturating
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mrsAge_q <= 16'hFFFF;
            actAge_q <= 16'hFFFF;
            age_q <= '{default: 16'hFFFF};
        end else begin
            mrsAge_q <= inc(mrsAge_q, isMrs);
            actAge_q <= inc(actAge_q, isAct);
            for (int b = 0; b < 4; b++) age_q[b] <= inc(age_q[b], isAct && bk == 2'(b));
        end
    end
    // open banks and the burst length last set
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            open_q <= 4'h0;
            len_q <= 3'h0;
        end else begin
            if (isAct) open_q[bk] <= 1'b1;
            if (isPre) open_q <= sdramPins.addr[10] ? 4'h0 : open_q & ~(4'h1 << bk);
            if (isMrs) len_q <= sdramPins.addr[2:0];
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    AST_MRS_CKE: assert property (isMrs |-> sdramPins.cke && $past(sdramPins.cke, 2))
        else $error("mode set without clock enable");
    AST_MRS_IDLE: assert property (isMrs |-> open_q == 4'h0)
        else $error("mode set with a bank open");
    AST_RSC: assert property (lk && sb != 3'h7 |-> mrsAge_q >= RSC)
        else $error("command too soon after mode set");
    AST_RCD: assert property (isRd || isWr |-> open_q[bk] && age_q[bk] >= RCD)
        else $error("access to closed bank or too soon");
    AST_RC: assert property (isAct |-> !open_q[bk] && age_q[bk] >= RC)
        else $error("activate of open bank or row cycle short");
    AST_RRD: assert property (isAct |-> actAge_q >= RRD)
        else $error("activates too close");
    AST_RAS: assert property ((open_q & over) == 4'h0)
        else $error("bank open too long");
    AST_BST: assert property (isBst |-> len_q == `SCB_LEN_FULL)
        else $error("burst stop without full page");
    AST_WR_DQ: assert property (isWr |-> dqOe ##1 dqOe)
        else $error("write data not with command");
    AST_RD_FREE: assert property (isRd |-> ##1 (!dqOe) [*3])
        else $error("bus driven into read");
    AST_WAIT_ONE: assert property (!avsWaitRequest |=> avsWaitRequest)
        else $error("waitrequest low too long");
    AST_RD_ANS: assert property (avsRead && avsWaitRequest |=> !avsWaitRequest)
        else $error("read not answered");
endmodule : scb_sdram_ctrl_assertions

// File: verification/scb_sdram_model.sv
// behavioural sdram device facing the controller
`timescale 1ns/1ps
module scb_sdram_model
    import scb_pkg::*;
(
    input wire logic sdramClk,
    input wire scb_pins_t pins,
    input wire logic [15:0] dqOut,
    input wire logic dqOe,
    output logic [15:0] dqIn,
    output logic clash
);
    logic [15:0] mem [int];
    logic [15:0] pipe [4];
    logic [3:0] pv = 4'h0;
    logic [8:0] rS, wS;
    logic [1:0] rB, wB;
    logic ilv = 1'b0;
    logic dqmD = 1'b1;
    logic drv = 1'b0;
    int rI = 0, wI = 0, rN = 0, wN = 0, len = 8, cl = 2;
    // burst column order within the wrap block
    function automatic logic [8:0] col(input logic [8:0] s, input int i);
        logic [8:0] m;
        m = 9'(len - 1);
        if (ilv) return (s & ~m) | ((s ^ 9'(i)) & m);
        return (s & ~m) | ((s + 9'(i)) & m);
    endfunction : col
    initial begin
        dqIn = 16'h0;
        clash = 1'b0;
    end
    // commands and data sampled on the link clock rise
    always @(posedge sdramClk) begin
        if (drv && dqOe) clash = 1'b1;
        pv = pv << 1;
        for (int k = 3; k > 0; k--) pipe[k] = pipe[k - 1];
        if (!pins.csN) begin
            case ({pins.rasN, pins.casN, pins.weN})
                3'h0: begin
                    len = (pins.addr[2:0] == 3'h7) ? 512 : (1 << pins.addr[2:0]);
                    ilv = pins.addr[3];
                    cl = pins.addr[5:4];
                end
                3'h5: begin
                    {rS, rB, rI, rN, wN} = {pins.addr[8:0], pins.bank, 32'h0, len, 32'h0};
                end
                3'h4: begin
                    {wS, wB, wI, wN, rN} = {pins.addr[8:0], pins.bank, 32'h0, len, 32'h0};
                end
                3'h6: {rN, wN} = 64'h0;
                default: ;
            endcase
        end
        if (wN > 0) begin
            if (pins.dqm == 2'h0) mem[{wB, col(wS, wI)}] = dqOut;
            wI++;
            wN--;
        end
        if (rN > 0) begin
            pipe[0] = mem.exists({rB, col(rS, rI)}) ? mem[{rB, col(rS, rI)}] : 16'h0;
            pv[0] = 1'b1;
            rI++;
            rN--;
        end
        drv = pv[cl - 1] && !dqmD;
        dqIn = drv ? pipe[cl - 1] : ~dqIn;
        dqmD = pins.dqm[0];
    end
endmodule : scb_sdram_model

// File: verification/scb_sdram_ctrl_tb.sv
// self-checking bench of the sdram command and burst controller
`timescale 1ns/1ps
module scb_sdram_ctrl_tb
    import scb_pkg::*;
;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] avsAddress = 4'h0;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h0;
    logic [31:0] avsReadData, rd;
    logic avsWaitRequest, sdramClk, dqOe, clash;
    scb_pins_t sdramPins;
    logic [15:0] dqOut, dqIn;
    logic [15:0] bufW [8];
    logic [31:0] lfsr_q = 32'h86DE;
    int lens [5] = '{7, 0, 1, 2, 3};
    int ilv = 0;
    int n_errors = 0;
    int n_tests = 0;
    always #50 clock = ~clock;
    scb_sdram_ctrl #(.DATA_W(16)) dut_u (.clock(clock), .resetn(resetn), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .sdramClk(sdramClk), .sdramPins(sdramPins), .dqOut(dqOut),
        .dqOe(dqOe), .dqIn(dqIn));
    scb_sdram_model mem_u (.sdramClk(sdramClk), .pins(sdramPins), .dqOut(dqOut), .dqOe(dqOe),
        .dqIn(dqIn), .clash(clash));
    // ****************************************
    // bus tasks and comparison
    // ****************************************
    task automatic complete_run;
        if (n_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("Error %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clock);
        avsRead <= !w;
        avsWrite <= w;
        avsAddress <= a;
        avsWriteData <= d;
        do begin
            @(posedge clock);
            t++;
        end while (avsWaitRequest !== 1'b0 && t < 4000);
        if (t >= 4000) n_errors++;
        rd = avsReadData;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask : av
    task automatic wt(input logic [31:0] m);
        int t;
        t = 0;
        do begin
            av(1'b0, 4'h1, 32'h0);
            t++;
        end while ((rd & m) != 32'h0 && t < 500);
        if (t >= 500) n_errors++;
    endtask : wt
    task automatic cmd(input scb_op_t op, input logic [1:0] b, input logic [12:0] a);
        av(1'b1, 4'h0, {11'h0, a, 2'h0, b, 1'b0, op});
        wt(32'h1);
    endtask : cmd
    // next state of the random source
    function automatic logic [31:0] lfsrNext(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsrNext
    task automatic fill;
        for (int k = 0; k < 8; k++) begin
            lfsr_q = lfsrNext(lfsr_q);
            bufW[k] = lfsr_q[15:0];
            av(1'b1, 4'(8 + k), {16'h0, bufW[k]});
        end
    endtask : fill
    task automatic rdchk(input int n, input int s, input int m);
        wt(32'h3);
        repeat (20) @(posedge clock);
        for (int k = 0; k < n; k++) begin
            av(1'b0, 4'(8 + k), 32'h0);
            chk(rd, {16'h0, bufW[(ilv != 0) ? (s ^ k) : (s + k) % m]});
        end
    endtask : rdchk
    task automatic errchk;
        av(1'b0, 4'h1, 32'h0);
        chk(rd & 32'h4, 32'h4);
        av(1'b1, 4'h1, 32'h4);
    endtask : errchk
    // watchdog against a hang
    initial begin
        repeat (60000) @(posedge clock);
        n_errors++;
        complete_run();
    end
    // main sequence
    initial begin
        int m;
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        av(1'b0, 4'h2, 32'h0);
        chk(rd, 32'h23);
        av(1'b0, 4'h4, 32'h0);
        chk(rd, 32'h0);
        // every burst length: write a block, read it back from its last column, full page from column 0
        foreach (lens[i]) begin
            m = (lens[i] == 7) ? 8 : (1 << lens[i]);
            ilv = (i == 4) ? 8 : 0; // last pass runs interleaved
            cmd(SCB_OP_PRE, 2'h0, 13'h400);
            av(1'b1, 4'h2, 32'h20 | ilv | lens[i]);
            cmd(SCB_OP_MRS, 2'h0, 13'(32'h20 | ilv | lens[i]));
            cmd(SCB_OP_ACT, 2'(i), 13'(5 + i));
            fill();
            cmd(SCB_OP_WR, 2'(i), 13'h0);
            if (lens[i] == 7) cmd(SCB_OP_BST, 2'(i), 13'h0);
            wt(32'h3);
            cmd(SCB_OP_RD, 2'(i), 13'((lens[i] == 7) ? 0 : m - 1));
            if (lens[i] == 7) cmd(SCB_OP_BST, 2'(i), 13'h0);
            rdchk((lens[i] == 7) ? 1 : m, (lens[i] == 7) ? 0 : m - 1, m);
        end
        // write cutting a read, then read the new data back
        fill();
        cmd(SCB_OP_RD, 2'h0, 13'h0);
        cmd(SCB_OP_WR, 2'h0, 13'h0);
        wt(32'h3);
        cmd(SCB_OP_RD, 2'h0, 13'h0);
        rdchk(8, 0, 8);
        chk({31'h0, clash}, 32'h0);
        // refused commands
        cmd(SCB_OP_BST, 2'h0, 13'h0);
        errchk();
        cmd(SCB_OP_ACT, 2'h0, 13'h9);
        errchk();
        cmd(SCB_OP_RD, 2'h2, 13'h0);
        errchk();
        av(1'b0, 4'h0, 32'h0);
        chk(rd, {11'h0, 13'h0, 2'h0, 2'h2, 1'b0, SCB_OP_RD});
        av(1'b0, 4'h1, 32'h0);
        chk(rd & 32'hF4, 32'h10);
        complete_run();
    end
endmodule : scb_sdram_ctrl_tb
bind scb_sdram_ctrl scb_sdram_ctrl_assertions chk_u (.clock(clock), .resetn(resetn), .avsRead(avsRead),
    .avsWaitRequest(avsWaitRequest), .sdramClk(sdramClk), .sdramPins(sdramPins), .dqOe(dqOe));
